// File: logic/alu_pkg.sv
/*
 * Constants for the rotate and subtract-with-borrow datapath block:
 * register offsets, field positions, operation codes, reset values.
 * Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
 */
package alu_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FILE_AW = 6;
    localparam int FILE_DEPTH = 64;
    localparam int BUS_AW = 12;
    localparam int BUS_DW = 32;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_WORK = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_RESULT = 12'h00c;
    localparam logic [3:0] FILE_PAGE = 4'h1;
    localparam int PAGE_LSB = 8;
    localparam int WORD_LSB = 2;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_DEST_BIT = 2;
    localparam int CTRL_FADDR_LSB = 8;
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_HALF_BIT = 1;
    localparam int STAT_ZERO_BIT = 2;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [1:0] OP_ROTATE_LEFT = 2'h0;
    localparam logic [1:0] OP_ROTATE_RIGHT = 2'h1;
    localparam logic [1:0] OP_SUBTRACT = 2'h2;
    localparam logic DEST_WORK = 1'h0;
    localparam logic DEST_FILE = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : alu_pkg

// File: logic/alu_core.sv
/*
 * Combinational rotate-through-carry and subtract-with-borrow unit.
 * Assumes the caller latches the result and flags on its own clock.
 */
`timescale 1ns/1ps
module alu_core
    import alu_pkg::*;
(
    input wire logic [1:0] op,
    input wire logic [7:0] operand,
    input wire logic [7:0] work,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out,
    output logic half_out,
    output logic zero_out
);

    logic [8:0] sum9;
    logic [4:0] nib5;

    // ----------------------------------------------------------------
    // Adder for subtract
    // ----------------------------------------------------------------
    always_comb begin
        sum9 = {1'h0, operand} + {1'h0, ~work} + {8'h00, carry_in};
        nib5 = {1'h0, operand[3:0]} + {1'h0, ~work[3:0]} + {4'h0, carry_in};
    end

    // ----------------------------------------------------------------
    // Operation select
    // ----------------------------------------------------------------
    always_comb begin
        result = operand;
        carry_out = carry_in;
        half_out = 1'h0;
        unique case (op)
            OP_ROTATE_LEFT: begin
                result = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            OP_ROTATE_RIGHT: begin
                result = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            OP_SUBTRACT: begin
                result = sum9[7:0];
                carry_out = sum9[8];
                half_out = nib5[4];
            end
            default: begin
                result = operand;
                carry_out = carry_in;
            end
        endcase
        zero_out = (result == RST_BYTE);
    end

endmodule : alu_core

// File: logic/file_bank.sv
/*
 * File register storage in flip-flops, one write port, two read ports.
 * Assumes one writer per cycle, chosen by the caller.
 */
`timescale 1ns/1ps
module file_bank #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [W-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [W-1:0] rdata_b
);

    logic [W-1:0] mem_r [DEPTH];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    assign rdata_a = mem_r[raddr_a];
    assign rdata_b = mem_r[raddr_b];

endmodule : file_bank

// File: logic/rotate_subtract_borrow_alu.sv
/*
 * Rotate-through-carry and subtract-with-borrow datapath with its
 * working register, file registers and status flags, behind an
 * AXI4-Lite slave. A write to the control register with a legal op and wstrb bits 0 and 1 set runs one instruction.
 * Assumes a single AXI4-Lite master on aclk with synchronous reset.
 */
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rotate_subtract_borrow_alu
    import alu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [BUS_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [BUS_DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [BUS_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [BUS_DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_file_addr(input logic [BUS_AW-1:0] a);
        return (a[BUS_AW-1:PAGE_LSB] == FILE_PAGE) && (a[WORD_LSB-1:0] == 2'h0);
    endfunction : is_file_addr

    function automatic logic [FILE_AW-1:0] file_index(input logic [BUS_AW-1:0] a);
        return a[WORD_LSB +: FILE_AW];
    endfunction : file_index

    function automatic logic is_reg_addr(input logic [BUS_AW-1:0] a);
        return (a == OFS_CTRL) || (a == OFS_WORK) || (a == OFS_STATUS) ||
            (a == OFS_RESULT);
    endfunction : is_reg_addr

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic aw_full_r;
    logic [BUS_AW-1:0] aw_addr_r;
    logic w_full_r;
    logic [BUS_DW-1:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [BUS_DW-1:0] rdata_r;
    logic [BUS_DW-1:0] rdata_nxt;
    logic [1:0] rresp_nxt;

    logic [7:0] work_r;
    logic carry_r;
    logic half_r;
    logic zero_r;
    logic [15:0] ctrl_r;
    logic [7:0] result_r;

    logic commit;
    logic wr_ctrl;
    logic wr_work;
    logic wr_status;
    logic wr_file;
    logic mapped;
    logic exec;
    logic op_legal;
    logic [1:0] op;
    logic dest;
    logic [FILE_AW-1:0] faddr;
    logic [7:0] operand;
    logic [7:0] alu_result;
    logic alu_carry;
    logic alu_half;
    logic alu_zero;
    logic bank_we;
    logic [FILE_AW-1:0] bank_waddr;
    logic [7:0] bank_wdata;
    logic [7:0] bus_file_data;
    logic [1:0] bresp_nxt;

    // ----------------------------------------------------------------
    // Write address and data channels
    // ----------------------------------------------------------------
    assign awready = !aw_full_r && !bvalid_r;
    assign wready = !w_full_r && !bvalid_r;
    assign commit = aw_full_r && w_full_r && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'h0;
            aw_addr_r <= '0;
        end else if (awvalid && awready) begin
            aw_full_r <= 1'h1;
            aw_addr_r <= awaddr;
        end else if (commit) begin
            aw_full_r <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'h0;
            w_data_r <= RST_WORD;
            w_strb_r <= 4'h0;
        end else if (wvalid && wready) begin
            w_full_r <= 1'h1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end else if (commit) begin
            w_full_r <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    assign wr_ctrl = commit && (aw_addr_r == OFS_CTRL);
    assign wr_work = commit && (aw_addr_r == OFS_WORK) && w_strb_r[0];
    assign wr_status = commit && (aw_addr_r == OFS_STATUS) && w_strb_r[0];
    assign wr_file = commit && is_file_addr(aw_addr_r) && w_strb_r[0];
    assign mapped = is_reg_addr(aw_addr_r) || is_file_addr(aw_addr_r);

    assign op = w_data_r[CTRL_OP_LSB +: 2];
    assign dest = w_data_r[CTRL_DEST_BIT];
    assign faddr = w_data_r[CTRL_FADDR_LSB +: FILE_AW];
    assign op_legal = (op == OP_ROTATE_LEFT) || (op == OP_ROTATE_RIGHT) ||
        (op == OP_SUBTRACT);
    assign exec = wr_ctrl && (w_strb_r[1:0] == 2'h3) && op_legal;

    always_comb begin
        bresp_nxt = RESP_OKAY;
        if (!mapped) begin
            bresp_nxt = RESP_SLVERR;
        end else if ((aw_addr_r == OFS_CTRL) && !((w_strb_r[1:0] == 2'h3) && op_legal)) begin
            bresp_nxt = RESP_SLVERR;
        end
    end

    // ----------------------------------------------------------------
    // Write response channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'h0;
            bresp_r <= RESP_OKAY;
        end else if (commit) begin
            bvalid_r <= 1'h1;
            bresp_r <= bresp_nxt;
        end else if (bready) begin
            bvalid_r <= 1'h0;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    alu_core u_alu (
        .op(op),
        .operand(operand),
        .work(work_r),
        .carry_in(carry_r),
        .result(alu_result),
        .carry_out(alu_carry),
        .half_out(alu_half),
        .zero_out(alu_zero)
    );

    always_comb begin
        bank_we = wr_file;
        bank_waddr = file_index(aw_addr_r);
        bank_wdata = w_data_r[7:0];
        if (exec && (dest == DEST_FILE)) begin
            bank_we = 1'h1;
            bank_waddr = faddr;
            bank_wdata = alu_result;
        end
    end

    file_bank #(
        .DEPTH(FILE_DEPTH),
        .AW(FILE_AW),
        .W(DATA_W)
    ) u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(bank_we),
        .waddr(bank_waddr),
        .wdata(bank_wdata),
        .raddr_a(faddr),
        .rdata_a(operand),
        .raddr_b(file_index(araddr)),
        .rdata_b(bus_file_data)
    );

    // ----------------------------------------------------------------
    // Working register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            work_r <= RST_BYTE;
        end else if (exec && (dest == DEST_WORK)) begin
            work_r <= alu_result;
        end else if (wr_work) begin
            work_r <= w_data_r[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_r <= RST_FLAGS[STAT_CARRY_BIT];
            half_r <= RST_FLAGS[STAT_HALF_BIT];
            zero_r <= RST_FLAGS[STAT_ZERO_BIT];
        end else if (exec) begin
            carry_r <= alu_carry;
            if (op == OP_SUBTRACT) begin
                half_r <= alu_half;
                zero_r <= alu_zero;
            end
        end else if (wr_status) begin
            carry_r <= w_data_r[STAT_CARRY_BIT];
            half_r <= w_data_r[STAT_HALF_BIT];
            zero_r <= w_data_r[STAT_ZERO_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Last control word and result
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= RST_WORD[15:0];
            result_r <= RST_BYTE;
        end else if (exec) begin
            ctrl_r <= w_data_r[15:0];
            result_r <= alu_result;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign arready = !rvalid_r;

    always_comb begin
        rdata_nxt = RST_WORD;
        rresp_nxt = RESP_OKAY;
        if (is_file_addr(araddr)) begin
            rdata_nxt[7:0] = bus_file_data;
        end else begin
            unique case (araddr)
                OFS_CTRL: rdata_nxt[15:0] = ctrl_r;
                OFS_WORK: rdata_nxt[7:0] = work_r;
                OFS_STATUS: begin
                    rdata_nxt[STAT_CARRY_BIT] = carry_r;
                    rdata_nxt[STAT_HALF_BIT] = half_r;
                    rdata_nxt[STAT_ZERO_BIT] = zero_r;
                end
                OFS_RESULT: rdata_nxt[7:0] = result_r;
                default: rresp_nxt = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'h0;
            rdata_r <= RST_WORD;
            rresp_r <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'h1;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end else if (rready) begin
            rvalid_r <= 1'h0;
        end
    end

    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

endmodule : rotate_subtract_borrow_alu

// File: sim/rotate_subtract_borrow_alu_props.sv
/*
 * Checker for the bus timing of the rotate and subtract datapath block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module rotate_subtract_borrow_alu_props
    import alu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [BUS_DW-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence write_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence read_taken;
        arvalid && arready;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_read_latency: assert property (read_taken |=> rvalid)
        else $error("read answer not one cycle after request");
    a_write_latency: assert property (write_taken |=> !bvalid ##1 bvalid)
        else $error("write answer not at commit edge");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before taken");
    a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer changed before taken");
    a_read_drop: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read answer not released");
    a_write_gate: assert property (bvalid |-> !awready && !wready)
        else $error("write ready high while answer pending");
    a_error_data: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == RST_WORD)
        else $error("refused read returned data");
    a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_write_drop: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer not released");
endmodule : rotate_subtract_borrow_alu_props

// File: sim/rotate_subtract_borrow_alu_test.sv
/*
 * Self-checking bench for the rotate and subtract datapath block.
 * Assumes the design package and the checker file are compiled first.
 */
`timescale 1ns/1ps
module rotate_subtract_borrow_alu_test
    import alu_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [10:0] exp;
    int failures, compares;
    logic [7:0] fv[6] = '{8'ha5, 8'h05, 8'h05, 8'h06, 8'h06, 8'h80};
    logic [7:0] wv[6] = '{8'h06, 8'h06, 8'h06, 8'h05, 8'h05, 8'h7f};
    logic [2:0] sv[6] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h6};
    logic [5:0] av[6] = '{6'h00, 6'h3f, 6'h05, 6'h20, 6'h11, 6'h01};

    rotate_subtract_borrow_alu i_rotate_subtract_borrow_alu (.aclk, .aresetn, .awaddr,
        .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
            input int lag = 0);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (lag == 0);
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && lag > 0) lag--;
            if (lag == 0 && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input int lag = 0);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (lag == 0);
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && lag > 0) lag--;
            if (lag == 0 && !rready) rready <= 1'b1;
        end while (!(rvalid && rready));
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd

    // ----------------------------------------------------------------
    // Compare tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic cmp_resp(input string n, input logic [1:0] e);
        compares++;
        if (resp !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, resp);
        end
    endtask : cmp_resp

    task automatic chk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        cmp_resp("read response", RESP_OKAY);
        cmp($sformatf("read %h", a), e, got);
    endtask : chk

    task automatic put(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        wr(a, d, s);
        cmp_resp($sformatf("write %h", a), RESP_OKAY);
    endtask : put

    function automatic logic [11:0] fa(input logic [5:0] n);
        fa = {FILE_PAGE, n, 2'b00};
    endfunction : fa

    function automatic logic [31:0] ctl(input int op, input int dst, input logic [5:0] n);
        ctl = {16'h0000, 2'b00, n, 5'b00000, dst[0], op[1:0]};
    endfunction : ctl

    // Expected {zero, half, carry, result}
    function automatic logic [10:0] model(input int op, input logic [7:0] f,
            input logic [7:0] w, input logic [2:0] st);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, f} + {1'b0, ~w} + {8'h00, st[0]};
        h = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + {4'h0, st[0]};
        case (op)
            0: model = {st[2:1], f[7], f[6:0], st[0]};
            1: model = {st[2:1], f[0], st[0], f[7:1]};
            default: model = {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
        endcase
    endfunction : model

    task automatic end_sim;
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Clock, reset, watchdog
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    initial begin
        #5_000_000;
        failures++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        failures = 0;
        compares = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        chk(OFS_STATUS, RST_WORD);
        chk(fa(6'h3f), RST_WORD);
        for (int op = 0; op < 3; op++) begin
            for (int dst = 0; dst < 2; dst++) begin
                for (int i = 0; i < 6; i++) begin
                    put(fa(av[i]), {24'h0, fv[i]}, 4'h1);
                    put(OFS_WORK, {24'h0, wv[i]}, 4'h1);
                    put(OFS_STATUS, {29'h0, sv[i]}, 4'h1);
                    put(OFS_CTRL, ctl(op, dst, av[i]), 4'h3);
                    exp = model(op, fv[i], wv[i], sv[i]);
                    chk(OFS_STATUS, {29'h0, exp[10:8]});
                    chk(OFS_RESULT, {24'h0, exp[7:0]});
                    chk(OFS_WORK, {24'h0, dst ? wv[i] : exp[7:0]});
                    chk(fa(av[i]), {24'h0, dst ? exp[7:0] : fv[i]});
                end
            end
        end
        put(fa(6'h02), 32'h0000_00a5, 4'h1);
        put(OFS_STATUS, RST_WORD, 4'h1);
        put(OFS_CTRL, ctl(0, 1, 6'h02), 4'h3);
        put(OFS_CTRL, ctl(0, 1, 6'h02), 4'h3);
        chk(fa(6'h02), 32'h0000_0095);
        chk(OFS_STATUS, RST_WORD);
        wr(OFS_CTRL, ctl(3, 1, 6'h02), 4'h3);
        cmp_resp("bad op", RESP_SLVERR);
        wr(OFS_CTRL, ctl(1, 1, 6'h02), 4'h1);
        cmp_resp("short strobe", RESP_SLVERR);
        chk(fa(6'h02), 32'h0000_0095);
        chk(OFS_CTRL, ctl(0, 1, 6'h02));
        put(OFS_RESULT, 32'h0000_00ff, 4'h1);
        chk(OFS_RESULT, 32'h0000_0095);
        wr(12'h010, 32'h0000_00ff, 4'hf);
        cmp_resp("unmapped write", RESP_SLVERR);
        rd(12'h010);
        cmp_resp("unmapped read", RESP_SLVERR);
        cmp("unmapped data", RST_WORD, got);
        wr(OFS_WORK, 32'h0000_005a, 4'h1, 2);
        cmp_resp("late write answer", RESP_OKAY);
        rd(OFS_WORK, 2);
        cmp_resp("late read answer", RESP_OKAY);
        cmp("late read data", 32'h0000_005a, got);
        put(OFS_WORK, 32'h0000_00c3, 4'h2);
        chk(OFS_WORK, 32'h0000_005a);
        end_sim();
    end
endmodule : rotate_subtract_borrow_alu_test

bind rotate_subtract_borrow_alu rotate_subtract_borrow_alu_props i_rotate_subtract_borrow_alu_props (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
